// *** rtl/sfdpr_top.sv ***
// serial reader of the first standard parameter table
// Notes on behaviour
// - 4 KB erase code 01b in bits 1:0, erase opcode 20h at 31h.
// - write granularity bit 2 reads 1, buffer of 64 bytes or more.
// - bit 3 says whether write enable precedes volatile status writes; 30h is E5h.
// - bit 4 picks write-enable opcode 50h or 06h; reported as 0.
// - nonvolatile status register gives bits 3 and 4 as 00b.
// - bits 7:5 of byte 30h always read 111b.
// - bit 16 set, 1-1-2 fast read supported.
// - address width bits 18:17 read 00b, three-byte only.
// - bit 19 reads 0, no double transfer rate.
// - bits 20, 21, 22 read 0, those fast reads unsupported.
// - 1-4-4 wait states at 38h bits 4:0 read zero.
// - 1-4-4 and 1-1-4 mode-bit fields read 000b.
// - byte 39h reads FFh.
// - 1-1-4 wait states at 3Ah read zero.
// - byte 3Bh reads FFh.
// - select low, 5Ah, three address, one dummy, then bytes until select rises.
// - table starts at byte address 30h.
`timescale 1ns/1ps
`default_nettype none
module sfdpr_top #(
   parameter logic [31:0] DENSITY = sfdpr_pkg::SFDPR_DENSITY_DFLT
) (
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   sck,
   input  wire logic                   cs_n,
   input  wire logic                   si,
   output var sfdpr_pkg::sfdpr_so_type so_q,
   output var  logic                   busy_q,
   output var  logic [7:0]             last_addr_q
);
   import sfdpr_pkg::*;

   // ----------------------------------------------------------------
   // link domain: serial clock, frame reset by chip select
   // ----------------------------------------------------------------
   sfdpr_state_type st_q;
   logic [4:0]      bit_q;       // bits received in current byte
   logic [7:0]      sh_q;        // incoming shift register
   logic [1:0]      abyte_q;     // address bytes received
   logic [7:0]      addr_q;      // table byte address
   logic [7:0]      tx_q;        // outgoing byte
   logic [2:0]      txbit_q;
   logic            so_bit_q;
   logic            so_en_q;
   logic            data_ph_q;   // high from table data start to deselect
   logic [7:0]      start_addr_q; // first table byte of this frame
   logic [7:0]      rd_addr;
   logic [7:0]      rom_q;
   logic [7:0]      nxt_byte;

   assign nxt_byte = {sh_q[6:0], si};

   // receive command, address and dummy on rising edge
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         st_q    <= SFDPR_ST_CMD;
         bit_q   <= 5'h00;
         sh_q    <= 8'h00;
         abyte_q <= 2'h0;
         addr_q  <= 8'h00;
         data_ph_q    <= 1'b0;
         start_addr_q <= 8'h00;
      end else begin
         sh_q <= nxt_byte;
         if (bit_q == 5'h07) begin
            bit_q <= 5'h00;
         end else begin
            bit_q <= bit_q + 5'h01;
         end
         unique case (st_q)
            SFDPR_ST_CMD: begin
               if (bit_q == 5'h07) begin
                  st_q <= (nxt_byte == SFDPR_OPC_READ_TABLE) ?
                          SFDPR_ST_ADDR : SFDPR_ST_IGN;
               end
            end
            SFDPR_ST_ADDR: begin
               if (bit_q == 5'h07) begin
                  addr_q  <= nxt_byte;                            // low byte wins
                  abyte_q <= abyte_q + 2'h1;
                  if (abyte_q == 2'h2) begin
                     st_q <= SFDPR_ST_DUMMY;
                  end
               end
            end
            SFDPR_ST_DUMMY: begin
               if (bit_q == 5'h07) begin
                  st_q        <= SFDPR_ST_DATA;
                  data_ph_q    <= 1'b1;
                  start_addr_q <= addr_q;
                  addr_q      <= addr_q + 8'h01;                  // prefetch next
               end
            end
            SFDPR_ST_DATA: begin
               if (bit_q == 5'h07) begin
                  addr_q <= addr_q + 8'h01;
               end
            end
            SFDPR_ST_IGN: begin
               st_q <= SFDPR_ST_IGN;
            end
            default: st_q <= SFDPR_ST_IGN;
         endcase
      end
   end

   // rom address: during dummy the addressed byte, later the prefetch
   assign rd_addr = addr_q;

   sfdpr_rom #(
      .DENSITY (DENSITY)
   ) u_rom (
      .clk     (sck),
      .addr    (rd_addr),
      .rdata_q (rom_q)
   );

   // shift table bytes out msb first on falling edge
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         tx_q     <= 8'h00;
         txbit_q  <= 3'h0;
         so_bit_q <= 1'b0;
         so_en_q  <= 1'b0;
      end else if (st_q == SFDPR_ST_DATA) begin
         if (txbit_q == 3'h0) begin
            so_bit_q <= rom_q[7];
            tx_q     <= {rom_q[6:0], 1'b0};
         end else begin
            so_bit_q <= tx_q[7];
            tx_q     <= {tx_q[6:0], 1'b0};
         end
         txbit_q <= txbit_q + 3'h1;
         so_en_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // system domain: synchronise and register status
   // ----------------------------------------------------------------
   logic [1:0] cs_sync_q;
   logic [2:0] tgl_sync_q;  // data phase flag, two stages plus edge stage

   // two-stage synchronisers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cs_sync_q  <= 2'h3;
         tgl_sync_q <= 3'h0;
      end else begin
         cs_sync_q  <= {cs_sync_q[0], cs_n};
         tgl_sync_q <= {tgl_sync_q[1:0], data_ph_q};
      end
   end

   // status: busy while selected, last table start address
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_q      <= 1'b0;
         last_addr_q <= SFDPR_TABLE_BASE;
      end else begin
         busy_q <= ~cs_sync_q[1];
         if (tgl_sync_q[1] && !tgl_sync_q[2]) begin
            last_addr_q <= start_addr_q;                          // stable for the frame
         end
      end
   end

   // serial output pin driven straight from link flops
   always_comb begin
      so_q.so_o  = so_bit_q;
      so_q.so_oe = so_en_q;                                       // cleared by deselect
   end
endmodule
`default_nettype wire

// *** rtl/sfdpr_pkg.sv ***
// package of constants and types for the discoverable-parameter table reader
package sfdpr_pkg;

   // ----------------------------------------------------------------
   // command and addressing
   // ----------------------------------------------------------------
   localparam logic [7:0] SFDPR_OPC_READ_TABLE = 8'h5A;
   localparam logic [7:0] SFDPR_TABLE_BASE     = 8'h30;
   localparam logic [7:0] SFDPR_TABLE_LAST     = 8'h3B;
   localparam logic [7:0] SFDPR_BLANK_BYTE     = 8'hFF;

   // ----------------------------------------------------------------
   // first parameter dword, byte 30h and 31h fields
   // ----------------------------------------------------------------
   localparam logic [1:0] SFDPR_ERASE_GRAN_4K  = 2'h1;
   localparam logic       SFDPR_WRITE_GRAN_BUF = 1'h1;
   localparam logic       SFDPR_WREN_REQ_VOL   = 1'h0;
   localparam logic       SFDPR_WREN_OPC_SEL   = 1'h0;
   localparam logic [2:0] SFDPR_B30_UNUSED     = 3'h7;
   localparam logic [7:0] SFDPR_ERASE_4K_OPC   = 8'h20;

   // ----------------------------------------------------------------
   // byte 32h fields
   // ----------------------------------------------------------------
   localparam logic       SFDPR_FR_112         = 1'h1;
   localparam logic [1:0] SFDPR_ADDR_3B_ONLY   = 2'h0;
   localparam logic       SFDPR_DTR_SUPPORT    = 1'h0;
   localparam logic       SFDPR_FR_122         = 1'h0;
   localparam logic       SFDPR_FR_144         = 1'h0;
   localparam logic       SFDPR_FR_114         = 1'h0;
   localparam logic       SFDPR_B32_UNUSED     = 1'h1;

   // ----------------------------------------------------------------
   // quad read fields, bytes 38h..3Bh
   // ----------------------------------------------------------------
   localparam logic [4:0] SFDPR_WAIT_NONE      = 5'h00;
   localparam logic [2:0] SFDPR_MODE_NONE      = 3'h0;
   localparam logic [7:0] SFDPR_OPC_UNSUPP     = 8'hFF;

   // density bytes 34h..37h: value not usable, report blank by default
   localparam logic [31:0] SFDPR_DENSITY_DFLT  = 32'hFFFF_FFFF;

   // ----------------------------------------------------------------
   // link-side state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SFDPR_ST_CMD   = 3'b000,
      SFDPR_ST_ADDR  = 3'b001,
      SFDPR_ST_DUMMY = 3'b010,
      SFDPR_ST_DATA  = 3'b011,
      SFDPR_ST_IGN   = 3'b100
   } sfdpr_state_type;

   // serial pins toward the host
   typedef struct packed {
      logic so_o;
      logic so_oe;
   } sfdpr_so_type;

endpackage

// *** rtl/sfdpr_rom.sv ***
// table storage: parameter bytes 30h..3Bh with registered read data
`timescale 1ns/1ps
`default_nettype none
module sfdpr_rom #(
   parameter logic [31:0] DENSITY = 32'hFFFF_FFFF
) (
   input  wire logic       clk,
   input  wire logic [7:0] addr,
   output var  logic [7:0] rdata_q
);
   import sfdpr_pkg::*;

   // ----------------------------------------------------------------
   // byte lookup
   // ----------------------------------------------------------------
   function automatic logic [7:0] table_byte(input logic [7:0] a);
      unique case (a)
         8'h30: table_byte = {SFDPR_B30_UNUSED, SFDPR_WREN_OPC_SEL,
                              SFDPR_WREN_REQ_VOL, SFDPR_WRITE_GRAN_BUF,
                              SFDPR_ERASE_GRAN_4K};
         8'h31: table_byte = SFDPR_ERASE_4K_OPC;
         8'h32: table_byte = {SFDPR_B32_UNUSED, SFDPR_FR_114, SFDPR_FR_144,
                              SFDPR_FR_122, SFDPR_DTR_SUPPORT,
                              SFDPR_ADDR_3B_ONLY, SFDPR_FR_112};
         8'h33: table_byte = SFDPR_BLANK_BYTE;
         8'h34: table_byte = DENSITY[7:0];
         8'h35: table_byte = DENSITY[15:8];
         8'h36: table_byte = DENSITY[23:16];
         8'h37: table_byte = DENSITY[31:24];
         8'h38: table_byte = {SFDPR_MODE_NONE, SFDPR_WAIT_NONE};
         8'h39: table_byte = SFDPR_OPC_UNSUPP;
         8'h3A: table_byte = {SFDPR_MODE_NONE, SFDPR_WAIT_NONE};
         8'h3B: table_byte = SFDPR_OPC_UNSUPP;
         default: table_byte = SFDPR_BLANK_BYTE;
      endcase
   endfunction

   // registered read port
   always_ff @(posedge clk) begin
      rdata_q <= table_byte(addr);
   end
endmodule
`default_nettype wire

// *** dv/sfdpr_top_props.sv ***
// checker of the table reader port behaviour
`timescale 1ns/1ps
`default_nettype none
module sfdpr_top_props (
   input wire logic                    clk,
   input wire logic                    sys_rst,
   input wire logic                    sck,
   input wire logic                    cs_n,
   input wire logic                    si,
   input wire sfdpr_pkg::sfdpr_so_type so_q,
   input wire logic                    busy_q,
   input wire logic [7:0]              last_addr_q
);
   import sfdpr_pkg::*;
   logic [5:0]  cnt_q;
   logic [39:0] hdr_q;
   logic [7:0]  rx_q;
   // ----------------------------------------------------------------
   // frame tracking, cleared while deselected
   // ----------------------------------------------------------------
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         cnt_q <= 6'h00;
         hdr_q <= 40'h00;
         rx_q  <= 8'h00;
      end else begin
         cnt_q <= (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
         hdr_q <= (cnt_q < 6'h28) ? {hdr_q[38:0], si} : hdr_q;
         rx_q  <= {rx_q[6:0], so_q.so_o};
      end
   end
   // first data byte complete for a read from address a
   sequence s_byte_done(logic [7:0] a);
      cnt_q == 6'h30 && hdr_q[39:32] == SFDPR_OPC_READ_TABLE && hdr_q[15:8] == a;
   endsequence
   property p_byte(logic [7:0] a, logic [7:0] v);
      @(posedge sck) disable iff (cs_n) s_byte_done(a) |-> rx_q == v;
   endproperty
   a_oe_selected: assert property (@(posedge clk) disable iff (sys_rst)
      so_q.so_oe |-> !cs_n) else $error("output driven while deselected");
   a_busy_rise: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(cs_n) |-> ##[1:5] busy_q) else $error("busy did not rise");
   a_busy_fall: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(cs_n) |-> ##[1:5] !busy_q) else $error("busy did not fall");
   a_addr_reset: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> last_addr_q == 8'h30) else $error("bad start address");
   a_oe_early: assert property (@(posedge sck) disable iff (cs_n)
      so_q.so_oe |-> cnt_q >= 6'h28 && hdr_q[39:32] == 8'h5A) else $error("early drive");
   a_oe_late: assert property (@(posedge sck) disable iff (cs_n)
      cnt_q >= 6'h28 && hdr_q[39:32] == 8'h5A |-> so_q.so_oe) else $error("no drive");
   a_byte_first: assert property (p_byte(8'h30, 8'hE5))
      else $error("byte 30 wrong");
   a_byte_erase: assert property (p_byte(8'h31, 8'h20))
      else $error("byte 31 wrong");
   a_byte_quad: assert property (p_byte(8'h38, 8'h00))
      else $error("byte 38 wrong");
endmodule
`default_nettype wire

// *** dv/sfdpr_host_model.sv ***
// host controller model issuing table read frames
`timescale 1ns/1ps
`default_nettype none
module sfdpr_host_model (
   output var logic sck,
   output var logic cs_n,
   output var logic si,
   input  wire logic so_o,
   input  wire logic so_oe
);
   logic lst = 1'b0;
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end
   // one frame: opcode, three address bytes, dummy byte, then nbits read
   task automatic frame(input logic [7:0] opc, input logic [7:0] adr, input int nbits,
                        output logic [95:0] rx, output int n_oe);
      logic [39:0] hdr;
      hdr  = {opc, 16'h0000, adr, 8'h00};
      rx   = 96'h0;
      n_oe = 0;
      #3.7 cs_n = 1'b0;
      for (int i = 0; i < 40 + nbits; i++) begin
         sck = 1'b0;
         si  = (i < 40) ? hdr[39 - i] : ~si; // toggling filler after header
         #40;
         lst  = so_oe ? so_o : ~lst; // released line shows no stale value
         n_oe = n_oe + int'(so_oe);
         rx   = {rx[94:0], lst};
         sck  = 1'b1;
         #40;
      end
      sck = 1'b0;
      #40 cs_n = 1'b1;
      #80;
   endtask
endmodule
`default_nettype wire

// *** dv/sfdpr_top_tb.sv ***
// self-checking bench of the serial table reader
`timescale 1ns/1ps
`default_nettype none
module sfdpr_top_tb;
   import sfdpr_pkg::*;
   localparam logic [95:0] EXP_TBL = 96'hE520_81FF_FFFF_FFFF_00FF_00FF;
   logic         clk = 1'b0;
   logic         sys_rst = 1'b1;
   logic         sck;
   logic         cs_n;
   logic         si;
   sfdpr_so_type so_q;
   logic         busy_q;
   logic [7:0]   last_addr_q;
   logic [95:0]  rx;
   int           n_oe;
   int           n_fail = 0;
   int           samples_checked = 0;
   int           cyc = 0;
   always #5 clk = ~clk;
   sfdpr_top i_sfdpr_top (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
                          .so_q(so_q), .busy_q(busy_q), .last_addr_q(last_addr_q));
   sfdpr_host_model i_host (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_q.so_o),
                            .so_oe(so_q.so_oe));
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_cnt(input string what, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         n_fail++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // whole table in one frame
   task automatic t_full();
      i_host.frame(SFDPR_OPC_READ_TABLE, 8'h30, 96, rx, n_oe);
      for (int b = 0; b < 12; b++) begin
         cmp8("table byte", EXP_TBL[95-8*b -: 8], rx[95-8*b -: 8]);
      end
      cmp_cnt("driven bits", 96, n_oe);
      cmp8("start address", 8'h30, last_addr_q);
      cmp8("busy", 8'h00, {7'h00, busy_q});
   endtask
   // quad read fields, started mid-table
   task automatic t_mid();
      i_host.frame(SFDPR_OPC_READ_TABLE, 8'h38, 32, rx, n_oe);
      for (int b = 0; b < 4; b++) begin
         cmp8("quad byte", EXP_TBL[31-8*b -: 8], rx[31-8*b -: 8]);
      end
      cmp8("start address", 8'h38, last_addr_q);
   endtask
   // other opcode never drives the output
   task automatic t_refuse();
      i_host.frame(8'h03, 8'h30, 16, rx, n_oe);
      cmp_cnt("driven bits", 0, n_oe);
   endtask
   // abort mid-byte, then a fresh read
   task automatic t_abort();
      i_host.frame(SFDPR_OPC_READ_TABLE, 8'h31, 4, rx, n_oe);
      cmp_cnt("driven bits", 4, n_oe);
      i_host.frame(SFDPR_OPC_READ_TABLE, 8'h31, 16, rx, n_oe);
      cmp8("erase opcode", 8'h20, rx[15:8]);
      cmp8("read modes", 8'h81, rx[7:0]);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      #1 sys_rst = 1'b0;
      @(posedge clk);
      #1 cmp8("reset address", 8'h30, last_addr_q);
      t_full();
      t_mid();
      t_refuse();
      t_abort();
      test_done();
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
endmodule
bind sfdpr_top sfdpr_top_props i_props (.clk(clk), .sys_rst(sys_rst), .sck(sck),
   .cs_n(cs_n), .si(si), .so_q(so_q), .busy_q(busy_q), .last_addr_q(last_addr_q));
`default_nettype wire
